// ==== hdl/clk_rst_pkg.sv ====
// package: constants and carrier types for the clock and reset manager
package clk_rst_pkg;
  localparam int          CLK_MHZ         = 200;
  localparam int          RC_START_CYCLES = 1024;
  localparam int          EXT_RST_MIN_NS  = 1000;
  localparam int          EXT_RST_CYCLES  = (EXT_RST_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int          RST_TIMER_CYC   = 4096;
  localparam int          WDT_CYCLES      = 1048576;
  localparam logic [23:0] BOOT_ADDR       = 24'h000000;
  localparam int          CFG_WORDS       = 8;
  localparam int          CFG_AW          = 3;

  typedef enum logic [1:0] {IFC_UART, IFC_SPI, IFC_I2C} host_ifc_t;

  typedef enum {ST_RESET, ST_FLASH_LOAD, ST_RUN} seq_state_t;

  typedef struct packed {
    logic       use_ext;
    logic       osc_fail;
  } clk_stat_t;

  typedef struct packed {
    logic        valid;
    logic [CFG_AW-1:0] addr;
    logic [23:0] data;
  } cfg_word_t;
endpackage

// ==== hdl/clk_select.sv ====
// clock source selection with rc start interval and fallback
`timescale 1ns/100ps
module clk_select (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   seq_restart_in,
  input  wire logic                   ext_present_in,
  input  wire logic                   ext_fail_in,
  output clk_rst_pkg::clk_stat_t      stat_out
);
  import clk_rst_pkg::*;

  typedef struct packed {
    logic [10:0] cnt;
    logic        use_ext;
    logic        fail;
  } sel_state_t;

  sel_state_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (seq_restart_in) begin
      s_nxt.cnt     = '0;
      s_nxt.use_ext = 1'b0;
    end else if (s_r.cnt < 11'(RC_START_CYCLES)) begin
      s_nxt.cnt = s_r.cnt + 11'h001;
    end else if (!s_r.use_ext && !s_r.fail && ext_present_in && !ext_fail_in) begin
      s_nxt.use_ext = 1'b1;
    end
    if (s_r.use_ext && ext_fail_in) begin
      s_nxt.use_ext = 1'b0;
      s_nxt.fail    = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign stat_out.use_ext  = s_r.use_ext;
  assign stat_out.osc_fail = s_r.fail;

  a_rc_first_interval: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_r.cnt < 11'(RC_START_CYCLES) |-> !s_r.use_ext)
    else $error("external clock chosen inside rc interval");
  a_ext_after_rc: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_r.cnt == 11'(RC_START_CYCLES) && !s_r.fail && ext_present_in && !ext_fail_in &&
      !seq_restart_in |=> s_r.use_ext)
    else $error("external clock not taken after rc interval");
  a_fallback_flag: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_r.use_ext && ext_fail_in |=> !s_r.use_ext && s_r.fail)
    else $error("no fallback on oscillator failure");
endmodule // clk_select

// ==== hdl/clock_reset_manager.sv ====
// top: reset sources, reset timer, straps and configuration reload
`timescale 1ns/100ps
// Notes on behaviour
// - after any reset the clock runs from rc oscillator for 1024 cycles
// - afterwards switch to external clock if present, else stay on rc (code: stays on rc once osc_fail is set, until rst_b_in)
// - external oscillator failure returns clock to rc automatically
// - oscillator failure and fallback shows in a readable status flag
// - external reset low halts digital logic; clock logic keeps running
// - external reset acts only after pin held low at least 1 us
// - internal reset holds until pin high and 4096-cycle timer expires
// - on release the processor starts fetching at address 0
// - power-on block resets logic below threshold, sequences once above
// - free-running watchdog times out into full reset; refresh restarts it
// - straps sampled at each reset select one of uart, spi, i2c
// - at reset, writable configuration reloads defaults from flash
module clock_reset_manager #(
  parameter int WDT_LIMIT = clk_rst_pkg::WDT_CYCLES,
  parameter int RST_TIMER = clk_rst_pkg::RST_TIMER_CYC
) (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   supply_ok_in,
  input  wire logic                   ext_reset_b_in,
  input  wire logic                   wdt_refresh_in,
  input  wire logic                   ext_present_in,
  input  wire logic                   ext_fail_in,
  input  wire logic                   interface_select_pin_a_in,
  input  wire logic                   interface_select_pin_b_in,
  input  wire logic [23:0]            flash_data_in,
  output logic      [clk_rst_pkg::CFG_AW-1:0] flash_addr_out,
  output clk_rst_pkg::cfg_word_t      cfg_load_out,
  output logic                        sys_reset_b_out,
  output logic      [23:0]            boot_addr_out,
  output clk_rst_pkg::host_ifc_t      host_ifc_out,
  output clk_rst_pkg::clk_stat_t      clk_stat_out,
  output logic                        wdt_reset_out
);
  import clk_rst_pkg::*;

  typedef struct packed {
    seq_state_t          st;
    logic [12:0]         rst_cnt;
    logic [7:0]          flt_cnt;
    logic [20:0]         wdt_cnt;
    logic                wdt_hit;
    host_ifc_t           ifc;
    logic [CFG_AW:0]     ld_idx;
    cfg_word_t           ld;
    logic                rel;
  } top_state_t;

  top_state_t s_r, s_nxt;
  logic       req;
  logic       ext_rst;
  logic       restart;

  function automatic host_ifc_t strap_dec(input logic a, input logic b);
    if (b)      return IFC_I2C;
    else if (a) return IFC_SPI;
    else        return IFC_UART;
  endfunction

  assign ext_rst = (s_r.flt_cnt >= 8'(EXT_RST_CYCLES));
  assign req     = !supply_ok_in || s_r.wdt_hit || ext_rst;
  assign restart = req && s_r.st != ST_RESET;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ld  = '0;
    if (ext_reset_b_in) begin
      s_nxt.flt_cnt = '0;
    end else if (s_r.flt_cnt < 8'(EXT_RST_CYCLES)) begin
      s_nxt.flt_cnt = s_r.flt_cnt + 8'h01;
    end
    s_nxt.wdt_hit = 1'b0;
    if (s_r.st != ST_RUN || wdt_refresh_in) begin
      s_nxt.wdt_cnt = '0;
    end else if (s_r.wdt_cnt >= 21'(WDT_LIMIT - 1)) begin
      s_nxt.wdt_cnt = '0;
      s_nxt.wdt_hit = 1'b1;
    end else begin
      s_nxt.wdt_cnt = s_r.wdt_cnt + 21'h000001;
    end
    case (s_r.st)
      ST_RESET: begin
        s_nxt.ld_idx = '0;
        if (req) begin
          s_nxt.rst_cnt = '0;
        end else if (s_r.rst_cnt >= 13'(RST_TIMER - 1)) begin
          s_nxt.ifc = strap_dec(interface_select_pin_a_in,
                                interface_select_pin_b_in);
          s_nxt.st  = ST_FLASH_LOAD;
        end else begin
          s_nxt.rst_cnt = s_r.rst_cnt + 13'h0001;
        end
      end
      ST_FLASH_LOAD: begin
        s_nxt.ld.valid = 1'b1;
        s_nxt.ld.addr  = s_r.ld_idx[CFG_AW-1:0];
        s_nxt.ld.data  = flash_data_in;
        s_nxt.ld_idx   = s_r.ld_idx + (CFG_AW+1)'(1);
        if (s_r.ld_idx == (CFG_AW+1)'(CFG_WORDS - 1)) begin
          s_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        s_nxt.rel = 1'b1;
      end
      default: s_nxt.st = ST_RESET;
    endcase
    if (req) begin
      s_nxt.st      = ST_RESET;
      s_nxt.rel     = 1'b0;
      s_nxt.ld      = '0;
      if (restart) s_nxt.rst_cnt = '0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  clk_select u_clk_select (
    .mclk_in        (mclk_in),
    .rst_b_in       (rst_b_in),
    .seq_restart_in (restart),
    .ext_present_in (ext_present_in),
    .ext_fail_in    (ext_fail_in),
    .stat_out       (clk_stat_out)
  );

  assign flash_addr_out  = s_r.ld_idx[CFG_AW-1:0];
  assign cfg_load_out    = s_r.ld;
  assign sys_reset_b_out = s_r.rel;
  assign boot_addr_out   = BOOT_ADDR;
  assign host_ifc_out    = s_r.ifc;
  assign wdt_reset_out   = s_r.wdt_hit;

  a_filter_min_low: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(ext_rst) |-> $past(ext_reset_b_in, EXT_RST_CYCLES) == 1'b0)
    else $error("pin reset taken before the minimum low time");
  a_filter_last_low: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ext_rst |-> $past(ext_reset_b_in) == 1'b0)
    else $error("pin reset request held with pin high");
  a_short_low_ignored: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ext_reset_b_in ##1 !ext_reset_b_in [*8] ##1 ext_reset_b_in |-> !ext_rst)
    else $error("short reset pulse took effect");
  a_pin_halts: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ext_rst |=> !sys_reset_b_out)
    else $error("logic not held while pin reset active");
  a_supply_reset: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !supply_ok_in |=> s_r.st == ST_RESET && !sys_reset_b_out)
    else $error("low supply did not reset");
  a_timer_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_r.st == ST_RESET && s_r.rst_cnt < 13'(RST_TIMER - 1) |=> s_r.st == ST_RESET)
    else $error("reset left before timer expired");
  a_rst_exit: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_r.st == ST_FLASH_LOAD && $past(s_r.st) == ST_RESET |->
      $past(s_r.rst_cnt) == 13'(RST_TIMER - 1))
    else $error("load started before reset timer expired");
  a_same_sequence: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    req |=> s_r.st == ST_RESET && s_r.rst_cnt == 13'h0000)
    else $error("reset request did not restart the sequence");
  a_wdt_reset: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wdt_reset_out |=> s_r.st == ST_RESET && !sys_reset_b_out)
    else $error("watchdog timeout did not reset");
  a_wdt_only_run: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wdt_reset_out |-> $past(sys_reset_b_out))
    else $error("watchdog fired while not released");
  a_refresh_clears: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wdt_refresh_in && s_r.st == ST_RUN |=> s_r.wdt_cnt == 21'h000000)
    else $error("refresh did not restart watchdog");
  a_strap_stable: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_r.st == ST_RUN && $past(s_r.st) == ST_RUN |-> $stable(host_ifc_out))
    else $error("interface changed outside reset");
  a_strap_map: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_r.st == ST_FLASH_LOAD && $past(s_r.st) == ST_RESET |->
      host_ifc_out == ($past(interface_select_pin_b_in) ? IFC_I2C :
                       $past(interface_select_pin_a_in) ? IFC_SPI : IFC_UART))
    else $error("interface does not follow the straps");
  a_flash_reload: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_r.st == ST_FLASH_LOAD && !req |=> cfg_load_out.valid)
    else $error("no configuration reload");
  a_load_first: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(cfg_load_out.valid) |-> cfg_load_out.addr == 3'h0)
    else $error("reload did not start at word zero");
  a_load_order: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    cfg_load_out.valid && $past(cfg_load_out.valid) |->
      cfg_load_out.addr == $past(cfg_load_out.addr) + 3'h1)
    else $error("reload words out of order");
  a_load_data: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    cfg_load_out.valid |-> cfg_load_out.data == $past(flash_data_in) &&
      cfg_load_out.addr == $past(flash_addr_out))
    else $error("reload word differs from flash word");
  a_boot_zero: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(sys_reset_b_out) |-> boot_addr_out == 24'h000000 && $past(cfg_load_out.valid))
    else $error("release without finished reload or boot address not zero");
  a_release_held: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    sys_reset_b_out && !req |=> sys_reset_b_out)
    else $error("release dropped without a reset request");
  a_restart_rc: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    restart |=> ##1 !clk_stat_out.use_ext)
    else $error("reset did not return to rc clock");
  a_ext_select: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(clk_stat_out.use_ext) |-> $past(ext_present_in) && !$past(ext_fail_in))
    else $error("external clock chosen while absent or failing");
  a_fail_sticky: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $past(clk_stat_out.osc_fail) |-> clk_stat_out.osc_fail)
    else $error("oscillator failure flag lost");

  c_release: cover property (@(posedge mclk_in) disable iff (!rst_b_in) $rose(sys_reset_b_out));
  c_wdt: cover property (@(posedge mclk_in) disable iff (!rst_b_in) wdt_reset_out);
  c_pin: cover property (@(posedge mclk_in) disable iff (!rst_b_in) $rose(ext_rst));
  c_ext_clk: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(clk_stat_out.use_ext));
  c_fallback: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(clk_stat_out.osc_fail));
endmodule // clock_reset_manager

// ==== verif/ext_src_model.sv ====
// external clock source and reset pin driver model
`timescale 1ns/100ps
module ext_src_model (
  input  wire logic       mclk_in,
  input  wire logic       present_cmd_in,
  input  wire logic       fail_cmd_in,
  input  wire logic [8:0] pulse_len_in,
  input  wire logic       pulse_go_in,
  output logic            ext_present_out,
  output logic            ext_fail_out,
  output logic            ext_reset_b_out
);
  logic [8:0] low_cnt_r = 9'h000;
  logic       pres_r    = 1'b0;
  logic       fail_r    = 1'b0;
  always @(negedge mclk_in) begin
    pres_r <= present_cmd_in;
    fail_r <= fail_cmd_in;
    if (pulse_go_in) low_cnt_r <= pulse_len_in;
    else if (low_cnt_r != 9'h000) low_cnt_r <= low_cnt_r - 9'h001;
  end
  assign ext_present_out = pres_r;
  assign ext_fail_out    = fail_r;
  // pin low for the commanded count only
  assign ext_reset_b_out = (low_cnt_r == 9'h000);
endmodule // ext_src_model

// ==== verif/clock_reset_manager_tb_top.sv ====
// testbench: reset sequencing, clock selection, watchdog
`timescale 1ns/100ps
module clock_reset_manager_tb_top;
  import clk_rst_pkg::*;
  localparam int RT = 16;
  localparam int WD = 64;
  logic mclk_in = 0, rst_b_in = 0, supply_ok_in = 1, wdt_refresh_in = 0;
  logic pa = 0, pb = 0, pres = 1, fail = 0, go = 0, ref_en = 1;
  logic [8:0] len = 0;
  logic ext_rst_b, ext_pres, ext_fail, srst_b, wdt_rst;
  logic [CFG_AW-1:0] faddr;
  logic [23:0] boot;
  cfg_word_t cfg;
  host_ifc_t ifc;
  clk_stat_t stat;
  int n_mismatch = 0, num_checks = 0, cyc = 0, t0 = 0, n = 0, nwdt = 0;
  always #2.5 mclk_in = ~mclk_in;
  ext_src_model i_ext_src_model (.mclk_in, .present_cmd_in(pres), .fail_cmd_in(fail),
    .pulse_len_in(len), .pulse_go_in(go), .ext_present_out(ext_pres),
    .ext_fail_out(ext_fail), .ext_reset_b_out(ext_rst_b));
  clock_reset_manager #(.WDT_LIMIT(WD), .RST_TIMER(RT)) i_clock_reset_manager (
    .mclk_in, .rst_b_in, .supply_ok_in, .ext_reset_b_in(ext_rst_b), .wdt_refresh_in,
    .ext_present_in(ext_pres), .ext_fail_in(ext_fail), .interface_select_pin_a_in(pa),
    .interface_select_pin_b_in(pb), .flash_data_in({16'hC35A, 5'h00, faddr}),
    .flash_addr_out(faddr), .cfg_load_out(cfg), .sys_reset_b_out(srst_b),
    .boot_addr_out(boot), .host_ifc_out(ifc), .clk_stat_out(stat), .wdt_reset_out(wdt_rst));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (wdt_rst === 1'b1) nwdt++;
    if (cyc > 8000) begin
      n_mismatch++;
      complete_run();
    end
  end
  always @(negedge mclk_in) wdt_refresh_in <= ref_en && (cyc % 16 == 0);
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge mclk_in);
  endtask
  task automatic pulse(input int k);
    len <= 9'(k);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
  endtask
  // follows one reset sequence to its release
  task automatic seq_check(input host_ifc_t e_ifc, input int lo);
    int k = 0;
    int c = 0;
    while (srst_b !== 1'b1 && c < 600) begin
      @(posedge mclk_in);
      #1;
      if (cfg.valid === 1'b1) begin
        chk("cfg_addr", 24'(k), 24'(cfg.addr));
        chk("cfg_data", {16'hC35A, 5'h00, 3'(k)}, cfg.data);
        k++;
      end
      c++;
    end
    tick(1);
    chk("load_count", 24'(CFG_WORDS), 24'(k));
    chk("release_min", 24'h1, 24'(c > lo));
    chk("release_max", 24'h1, 24'(c <= RT + CFG_WORDS + 6));
    chk("boot_addr", BOOT_ADDR, boot);
    chk("host_ifc", 24'(e_ifc), 24'(ifc));
  endtask
  task automatic t_clock();
    tick(1000 - (cyc - t0));
    chk("rc_hold", 24'h0, 24'(stat.use_ext));
    n = 0;
    while (stat.use_ext !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    chk("ext_sel", 24'h1, 24'(stat.use_ext));
    chk("ext_sel_time", 24'h1, 24'(n > 20));
    fail <= 1'b1;
    tick(4);
    chk("fallback", 24'h0, 24'(stat.use_ext));
    chk("fail_flag", 24'h1, 24'(stat.osc_fail));
    fail <= 1'b0;
    $display("test clock done");
  endtask
  task automatic t_ext_reset();
    pa = 1;
    pulse(8);
    tick(20);
    chk("glitch_low", 24'h1, 24'(srst_b));
    pulse(150);
    tick(170);
    chk("short_low", 24'h1, 24'(srst_b));
    pulse(260);
    tick(190);
    chk("filter_hold", 24'h1, 24'(srst_b));
    tick(50);
    chk("pin_reset", 24'h0, 24'(srst_b));
    tick(25);
    seq_check(IFC_SPI, RT - 6);
    $display("test ext_reset done");
  endtask
  task automatic t_supply();
    pb = 1;
    supply_ok_in = 0;
    tick(5);
    chk("supply_reset", 24'h0, 24'(srst_b));
    supply_ok_in = 1;
    seq_check(IFC_I2C, RT);
    $display("test supply done");
  endtask
  task automatic t_wdt();
    tick(200);
    chk("wdt_quiet", 24'h0, 24'(nwdt));
    ref_en <= 1'b0;
    n = 0;
    while (nwdt == 0 && n < 120) begin
      tick(1);
      n++;
    end
    chk("wdt_fire", 24'h1, 24'(nwdt));
    chk("wdt_late", 24'h1, 24'(n > WD - 20));
    tick(3);
    ref_en <= 1'b1;
    chk("wdt_reset", 24'h0, 24'(srst_b));
    seq_check(IFC_I2C, RT - 8);
    $display("test wdt done");
  endtask
  task automatic t_no_ext();
    pres <= 1'b0;
    rst_b_in = 0;
    tick(2);
    chk("fail_clear", 24'h0, 24'(stat.osc_fail));
    rst_b_in = 1;
    seq_check(IFC_I2C, RT);
    tick(1100);
    chk("stay_rc", 24'h0, 24'(stat.use_ext));
    $display("test no_ext done");
  endtask
  initial begin
    tick(3);
    rst_b_in = 1;
    t0 = cyc;
    seq_check(IFC_UART, RT);
    $display("test power_up done");
    t_clock();
    t_ext_reset();
    t_supply();
    t_wdt();
    t_no_ext();
    complete_run();
  end
endmodule // clock_reset_manager_tb_top
